/* File: src/fbs_map.svh */
// fbs_map.svh: widths, state codes and reset values of the burst sram core
// assumes it is included by fbs_pkg and fbs_sram; definitions only
// Overview of operation
// - data moves one cycle after address
// - reads and writes follow back to back
// - clock enable high freezes all registers but the pin synchronisers
// - stalled edge leaves outputs untouched
// - load only when selected and enabled
// - deselect starts nothing, finishes pending transfer
// - pending transfer completes after deselect
// - bus floats after deselect or write
// - deselect on load with false enable
// - high chip enable mirrors active-low ones
// - up to four beats per address
// - low loads, high advances burst counter
// - address ignored while advancing
// - deselect load ends running burst
// - order select high interleaved, low linear
// - read/write picks op, data next cycle
// - per-lane write enables, write next cycle
// - lane enables ignored on reads
// - write data registered, read flows through
// - output enable high floats bus asynchronously
// - sleep gates clock, array kept
`ifndef FBS_MAP_SVH
`define FBS_MAP_SVH
`define FBS_ADDR_W 18
`define FBS_LANES 4
`define FBS_LANE_W 9
`define FBS_DATA_W (`FBS_LANES * `FBS_LANE_W)
`define FBS_DEPTH (1 << `FBS_ADDR_W)
`define FBS_CNT_W 2
`define FBS_CNT_ZERO 2'h0
`define FBS_CNT_ONE 2'h1
`define FBS_ST_IDLE 3'h1
`define FBS_ST_READ 3'h2
`define FBS_ST_WRITE 3'h4
`define FBS_SYNC_RST 2'h0
`define FBS_SYNC_SLEEP 0
`define FBS_SYNC_ORDER 1
`endif

/* File: src/fbs_pkg.sv */
// fbs_pkg: types shared by the burst sram core
// assumes fbs_map.svh is on the include path
`include "fbs_map.svh"
package fbs_pkg;
	// data phase owed on the next active edge
	typedef enum logic [2:0] {
		fbs_idle = `FBS_ST_IDLE,
		fbs_read = `FBS_ST_READ,
		fbs_write = `FBS_ST_WRITE
	} fbs_state_t;

	// operation captured on a load edge
	typedef struct packed {
		logic [`FBS_ADDR_W-1:0] base;
		logic [`FBS_CNT_W-1:0] count;
		logic [`FBS_LANES-1:0] lane_n;
	} fbs_op_t;
endpackage : fbs_pkg

/* File: src/fbs_sram.sv */
// fbs_sram: synchronous sram core, flow-through reads, 4-beat bursts
// assumes controller logic on the same clock drives the sync inputs;
// sleep and burst order arrive from pins and are synchronised here
`include "fbs_map.svh"
module fbs_sram (
	input wire logic clock,
	input wire logic rst,
	input wire logic clock_enable_n,
	input wire logic advance_or_load,
	input wire logic read_write_n,
	input wire logic chip_select_n_a,
	input wire logic chip_select_n_b,
	input wire logic chip_select_high,
	input wire logic [`FBS_LANES-1:0] byte_write_n,
	input wire logic [`FBS_ADDR_W-1:0] address_in,
	input wire logic burst_order_select,
	input wire logic output_enable_n,
	input wire logic sleep_request,
	input wire logic [`FBS_DATA_W-1:0] data_in,
	output logic [`FBS_DATA_W-1:0] data_out,
	output logic data_oe
);

	// bit 8 of each lane carries the parity_data_lines bit

	// pin synchronisers, first stage read only by second
	logic [1:0] sync_a;
	logic [1:0] sync_b;
	logic [1:0] next_sync_a;
	logic [1:0] next_sync_b;
	logic sleep_now;
	logic order_now;

	// control state
	fbs_pkg::fbs_state_t state;
	fbs_pkg::fbs_state_t next_state;
	fbs_pkg::fbs_op_t op;
	fbs_pkg::fbs_op_t next_op;

	// decoded cycle kinds
	logic active;
	logic selected;
	logic load;
	logic deselect;
	logic advance;
	logic mem_we;
	logic [`FBS_ADDR_W-1:0] cur_addr;

	// storage array, no reset: contents survive sleep
	logic [`FBS_DATA_W-1:0] mem [0:`FBS_DEPTH-1];

	// low address bits of the current beat
	function automatic logic [`FBS_CNT_W-1:0] fbs_burst_low(
		input logic [`FBS_CNT_W-1:0] start,
		input logic [`FBS_CNT_W-1:0] count,
		input logic interleave
	);
		logic [`FBS_CNT_W-1:0] low;
		low = interleave ? (start ^ count) : (start + count);
		return low;
	endfunction : fbs_burst_low

	// synchroniser next values
	always_comb begin
		next_sync_a = {burst_order_select, sleep_request};
		next_sync_b = sync_a;
	end

	// synchroniser registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sync_a <= `FBS_SYNC_RST;
			sync_b <= `FBS_SYNC_RST;
		end else begin
			sync_a <= next_sync_a;
			sync_b <= next_sync_b;
		end
	end

	assign sleep_now = sync_b[`FBS_SYNC_SLEEP];
	// order is static; sync only keeps a stray change clean
	assign order_now = sync_b[`FBS_SYNC_ORDER];

	// sleep behaves as a gated clock: every edge is dropped except by the pin synchronisers
	assign active = !clock_enable_n && !sleep_now;

	// all three enables must be true to select the chip
	assign selected = !chip_select_n_a && !chip_select_n_b
		&& chip_select_high;

	// load, deselect and advance are mutually exclusive
	assign load = active && !advance_or_load && selected;
	assign deselect = active && !advance_or_load && !selected;
	assign advance = active && advance_or_load;

	// address of the beat whose data moves this cycle
	assign cur_addr = {op.base[`FBS_ADDR_W-1:`FBS_CNT_W],
		fbs_burst_low(op.base[`FBS_CNT_W-1:0], op.count, order_now)};

	// next control state
	always_comb begin
		next_state = state;
		next_op = op;
		if (load) begin
			// read/write decides the data phase of the next cycle
			next_state = read_write_n ? fbs_pkg::fbs_read
				: fbs_pkg::fbs_write;
			next_op.base = address_in;
			next_op.count = `FBS_CNT_ZERO;
			next_op.lane_n = byte_write_n;
		end else if (deselect) begin
			// current beat still finishes on this edge
			next_state = fbs_pkg::fbs_idle;
		end else if (advance && state != fbs_pkg::fbs_idle) begin
			// address pins ignored; counter wraps after four beats
			next_op.count = op.count + `FBS_CNT_ONE;
			next_op.lane_n = byte_write_n;
		end
	end

	// control registers; a stalled edge changes nothing
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= fbs_pkg::fbs_idle;
			op <= '0;
		end else begin
			state <= next_state;
			op <= next_op;
		end
	end

	// write data is taken on the edge that ends the data phase
	assign mem_we = active && state == fbs_pkg::fbs_write;

	// lane writes; enables only matter in a write phase
	always_ff @(posedge clock) begin
		for (int i = 0; i < `FBS_LANES; i++) begin
			if (mem_we && !op.lane_n[i]) begin
				mem[cur_addr][i*`FBS_LANE_W +: `FBS_LANE_W]
					<= data_in[i*`FBS_LANE_W +: `FBS_LANE_W];
			end
		end
	end

	// flow-through read: no output register, so the word
	// follows the array directly during the read phase
	assign data_out = mem[cur_addr];

	// drive only in a read phase; output enable is asynchronous
	assign data_oe = (state == fbs_pkg::fbs_read)
		&& !output_enable_n;

	// checks on the decoded behaviour

	AST_READ_NEXT: assert property (
		@(posedge clock) disable iff (rst)
		load && read_write_n |=> state == fbs_pkg::fbs_read
	) else $error("load read did not start a read phase");

	AST_WRITE_NEXT: assert property (
		@(posedge clock) disable iff (rst)
		load && !read_write_n |=> state == fbs_pkg::fbs_write
			&& op.lane_n == $past(byte_write_n)
	) else $error("load write did not start a write phase");

	AST_BACK_TO_BACK: assert property (
		@(posedge clock) disable iff (rst)
		state == fbs_pkg::fbs_write && load && read_write_n
			|=> data_oe || output_enable_n
	) else $error("idle cycle inserted between write and read");

	AST_STALL_HOLD: assert property (
		@(posedge clock) disable iff (rst)
		!active |=> $stable(state) && $stable(op)
	) else $error("registers moved on a stalled edge");

	AST_STALL_OUT: assert property (
		@(posedge clock) disable iff (rst)
		!active && !output_enable_n ##1 !output_enable_n
			|-> $stable(data_oe)
	) else $error("output enable moved on a stalled edge");

	AST_NO_LOAD: assert property (
		@(posedge clock) disable iff (rst)
		!selected && !advance_or_load |=> $stable(op)
	) else $error("address captured while deselected");

	AST_DESELECT: assert property (
		@(posedge clock) disable iff (rst)
		deselect |=> state == fbs_pkg::fbs_idle ##1
			state == fbs_pkg::fbs_idle || $past(active)
	) else $error("deselect did not end the operation");

	AST_PENDING_WRITE: assert property (
		@(posedge clock) disable iff (rst)
		deselect && state == fbs_pkg::fbs_write |-> mem_we
	) else $error("pending write dropped by deselect");

	AST_FLOAT: assert property (
		@(posedge clock) disable iff (rst)
		active && (deselect || (load && !read_write_n))
			|=> !data_oe
	) else $error("bus driven after deselect or write");

	AST_OE_ASYNC: assert property (
		@(posedge clock) disable iff (rst)
		output_enable_n |-> !data_oe
	) else $error("bus driven with output enable high");

	AST_ADDR_IGNORED: assert property (
		@(posedge clock) disable iff (rst)
		advance_or_load |=> op.base == $past(op.base)
	) else $error("address taken while advancing");

	AST_BURST_STEP: assert property (
		@(posedge clock) disable iff (rst)
		advance && state != fbs_pkg::fbs_idle
			|=> op.count == $past(op.count) + `FBS_CNT_ONE
	) else $error("burst counter did not step");

	AST_FOUR_BEATS: assert property (
		@(posedge clock) disable iff (rst)
		load ##1 advance [*4] |=> op.count == `FBS_CNT_ZERO
	) else $error("burst did not wrap after four beats");

	AST_ORDER: assert property (
		@(posedge clock) disable iff (rst)
		order_now |-> cur_addr[`FBS_CNT_W-1:0]
			== (op.base[`FBS_CNT_W-1:0] ^ op.count)
	) else $error("interleaved order not applied");

	AST_READ_LANES: assert property (
		@(posedge clock) disable iff (rst)
		state == fbs_pkg::fbs_read |-> !mem_we
	) else $error("array written during a read phase");

	AST_SLEEP_HOLD: assert property (
		@(posedge clock) disable iff (rst)
		sleep_now |=> $stable(state) && $stable(op)
	) else $error("state moved while asleep");

	// a load takes the pins and restarts the beat count
	AST_LOAD_BASE: assert property (
		@(posedge clock) disable iff (rst)
		load |=> op.base == $past(address_in)
			&& op.count == `FBS_CNT_ZERO
	) else $error("load did not capture the address");

	// a load read drives the bus in the very next cycle
	AST_READ_DRIVE: assert property (
		@(posedge clock) disable iff (rst)
		load && read_write_n && !output_enable_n ##1 !output_enable_n
			|-> data_oe
	) else $error("load read did not drive the bus");

	// with nothing pending the core neither drives nor writes
	AST_IDLE_QUIET: assert property (
		@(posedge clock) disable iff (rst)
		state == fbs_pkg::fbs_idle
			|-> !data_oe && !mem_we
	) else $error("idle core touched the bus or array");

	// linear order wraps within the four-word group
	AST_LINEAR: assert property (
		@(posedge clock) disable iff (rst)
		!order_now |-> cur_addr[`FBS_CNT_W-1:0]
			== op.base[`FBS_CNT_W-1:0] + op.count
	) else $error("linear order not applied");

	// the counter never reaches past the low two bits
	AST_UPPER_FIXED: assert property (
		@(posedge clock) disable iff (rst)
		state != fbs_pkg::fbs_idle |-> cur_addr[`FBS_ADDR_W-1:`FBS_CNT_W]
			== op.base[`FBS_ADDR_W-1:`FBS_CNT_W]
	) else $error("burst moved the upper address bits");

	// an advance with no burst running starts nothing
	AST_ADVANCE_IDLE: assert property (
		@(posedge clock) disable iff (rst)
		advance && state == fbs_pkg::fbs_idle
			|=> state == fbs_pkg::fbs_idle && $stable(op)
	) else $error("advance started an operation");

	// enabled lane 0 holds the word taken on the write edge
	AST_LANE_WRITE: assert property (
		@(posedge clock) disable iff (rst)
		mem_we && !op.lane_n[0] |=> mem[$past(cur_addr)][`FBS_LANE_W-1:0]
			== $past(data_in[`FBS_LANE_W-1:0])
	) else $error("enabled lane not written");

	// a stalled or sleeping edge never writes the array
	AST_STALL_NO_WRITE: assert property (
		@(posedge clock) disable iff (rst)
		!active
			|-> !mem_we
	) else $error("array written on a stalled edge");

	// the bus stays released for the whole write phase
	AST_WRITE_QUIET: assert property (
		@(posedge clock) disable iff (rst)
		state == fbs_pkg::fbs_write
			|-> !data_oe
	) else $error("bus driven during a write phase");

endmodule : fbs_sram

/* File: verification/fbs_ctrl_model.sv */
// fbs_ctrl_model: memory controller side of the sram bus
// assumes the bench calls step once per cycle from one thread
module fbs_ctrl_model (
	input wire logic clock,
	output logic clock_enable_n,
	output logic advance_or_load,
	output logic read_write_n,
	output logic chip_select_n_a,
	output logic chip_select_n_b,
	output logic chip_select_high,
	output logic [3:0] byte_write_n,
	output logic [17:0] address_in,
	output logic [35:0] data_in
);
	timeunit 1ns;
	timeprecision 100ps;
	// park deselected until the bench drives
	initial begin
		clock_enable_n = 1'b0;
		advance_or_load = 1'b0;
		read_write_n = 1'b1;
		chip_select_n_a = 1'b0;
		chip_select_n_b = 1'b0;
		chip_select_high = 1'b0;
		byte_write_n = 4'hf;
		address_in = 18'h0_0000;
		data_in = 36'h0_0000_0000;
	end
	// c = {stall, advance, read, deselect kind}; idle data toggles
	// so a stale word never passes for a written one
	task automatic step(input logic [4:0] c, input logic [17:0] a,
		input logic [35:0] d, input logic [3:0] l, input logic v);
		@(posedge clock);
		#1;
		clock_enable_n = c[4];
		advance_or_load = c[3];
		read_write_n = c[2];
		chip_select_n_a = c[1:0] == 2'h1;
		chip_select_n_b = c[1:0] == 2'h2;
		chip_select_high = c[1:0] != 2'h3;
		byte_write_n = l;
		address_in = a;
		data_in = v ? d : ~data_in;
	endtask : step
endmodule : fbs_ctrl_model

/* File: verification/test_fbs_sram.sv */
// test_fbs_sram: bench for the burst sram core
// assumes fbs_ctrl_model stands in for the memory controller
module test_fbs_sram;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [4:0] op_lw = 5'h00, op_lr = 5'h04, op_ad = 5'h08;
	localparam logic [4:0] op_st = 5'h10, op_ds = 5'h07;
	logic clock, rst, clock_enable_n, advance_or_load, read_write_n;
	logic chip_select_n_a, chip_select_n_b, chip_select_high;
	logic [3:0] byte_write_n;
	logic [17:0] address_in;
	logic [35:0] data_in, data_out;
	logic data_oe, output_enable_n, sleep_request, burst_order_select;
	int fail_count, comparisons;
	fbs_sram fbs_sram_i (.clock, .rst, .clock_enable_n, .advance_or_load,
		.read_write_n, .chip_select_n_a, .chip_select_n_b,
		.chip_select_high, .byte_write_n, .address_in,
		.burst_order_select, .output_enable_n, .sleep_request,
		.data_in, .data_out, .data_oe);
	fbs_ctrl_model fbs_ctrl_model_i (.clock, .clock_enable_n,
		.advance_or_load, .read_write_n, .chip_select_n_a,
		.chip_select_n_b, .chip_select_high, .byte_write_n,
		.address_in, .data_in);
	// 40 mhz clock
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// reference word and beat address
	function automatic logic [35:0] pat(input logic [17:0] a);
		return {a, ~a};
	endfunction : pat
	function automatic logic [17:0] beat(input logic [17:0] a,
		input logic [1:0] k, input logic il);
		return {a[17:2], il ? a[1:0] ^ k : a[1:0] + k};
	endfunction : beat
	task automatic chk(input string n, input logic [35:0] s, e);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic cy(input logic [4:0] c, input logic [17:0] a,
		input logic [35:0] d = 36'h0_0000_0000, input logic [3:0] l = 4'h0,
		input logic v = 1'b0);
		fbs_ctrl_model_i.step(c, a, d, l, v);
	endtask : cy
	task automatic stop_test;
		$display("fails %0d comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test
	// single read; bus floats after the deselect
	task automatic rd1(input logic [17:0] a, input logic [35:0] e);
		cy(op_lr, a);
		cy(op_ds, ~a);
		chk("rd1 data", data_out, e);
		cy(op_ad, a);
		chk("rd1 float", data_oe, 1'b0);
	endtask : rd1
	// four beat read, load cycle may carry pending write data
	task automatic rd4(input logic [17:0] a, input logic il,
		input logic [35:0] d, input logic v);
		cy(op_lr, a, d, 4'h0, v);
		for (int k = 0; k < 4; k++) begin
			cy(k < 3 ? op_ad : op_ds, ~a);
			chk("bd", data_out, pat(beat(a, 2'(k), il)));
			chk("boe", data_oe, 1'b1);
		end
		cy(op_ad, a);
		cy(op_ad, a);
		chk("no restart", data_oe, 1'b0);
	endtask : rd4
	// linear burst write straight into a burst read
	task automatic t_burst(input logic [17:0] a);
		cy(op_lw, a);
		for (int k = 0; k < 3; k++)
			cy(op_ad, ~a, pat(beat(a, 2'(k), 1'b0)), 4'h0, 1'b1);
		rd4(a, 1'b0, pat(beat(a, 2'h3, 1'b0)), 1'b1);
	endtask : t_burst
	// four advances from one load wrap to the first beat
	task automatic t_wrap(input logic [17:0] a);
		cy(op_lr, a);
		for (int k = 0; k < 5; k++) begin
			cy(k < 4 ? op_ad : op_ds, ~a);
			chk("wrap", data_out, pat(beat(a, 2'(k), 1'b0)));
		end
		cy(op_ad, a);
	endtask : t_wrap
	// lane merge; lanes held low on reads must not write
	task automatic t_lanes(input logic [17:0] a);
		logic [35:0] m;
		m = 36'hf_f803_fe00;
		cy(op_lw, a);
		cy(op_lw, a, pat(a), 4'ha, 1'b1);
		cy(op_lr, a, ~pat(a), 4'h0, 1'b1);
		rd1(a, pat(a) & m | ~pat(a) & ~m);
	endtask : t_lanes
	// stalled edge mid burst, then output enable off
	task automatic t_stall(input logic [17:0] a);
		cy(op_lr, a);
		cy(op_st, ~a);
		cy(op_ad, ~a);
		chk("st hold", data_out, pat(a));
		cy(op_ds, ~a);
		chk("st beat1", data_out, pat(beat(a, 2'h1, 1'b0)));
		output_enable_n = 1'b1;
		#1 chk("oe off", data_oe, 1'b0);
		output_enable_n = 1'b0;
	endtask : t_stall
	// every select kind deselects yet the pending write lands
	task automatic t_desel(input logic [17:0] a);
		for (int s = 1; s < 4; s++) begin
			cy(op_lw, a + 18'(s));
			cy(op_lw | 5'(s), a, pat(a + 18'(s)), 4'h0, 1'b1);
			cy(op_lr, a + 18'(s));
			chk("ds float", data_oe, 1'b0);
			cy(op_lr | 5'(s), a);
			chk("ds pend", data_out, pat(a + 18'(s)));
			cy(op_ad, a);
			chk("ds none", data_oe, 1'b0);
		end
	endtask : t_desel
	// writes while asleep are dropped, contents kept
	task automatic t_sleep(input logic [17:0] a);
		sleep_request = 1'b1;
		repeat (3) cy(op_st, a);
		cy(op_lw, a);
		cy(op_ad, a, 36'h0_0000_0000, 4'h0, 1'b1);
		sleep_request = 1'b0;
		repeat (3) cy(op_st, a);
		rd1(a, pat(a));
	endtask : t_sleep
	// main sequence; order select only moves while stalled
	initial begin
		fail_count = 0;
		comparisons = 0;
		rst = 1'b1;
		output_enable_n = 1'b0;
		sleep_request = 1'b0;
		burst_order_select = 1'b0;
		repeat (16) @(posedge clock);
		#1 rst = 1'b0;
		t_burst(18'h0_0011);
		t_wrap(18'h0_0011);
		t_lanes(18'h0_0100);
		t_stall(18'h0_0011);
		t_desel(18'h0_0200);
		t_sleep(18'h0_0012);
		burst_order_select = 1'b1;
		repeat (3) cy(op_st, 18'h0_0000);
		rd4(18'h0_0011, 1'b1, 36'h0_0000_0000, 1'b0);
		stop_test();
	end
	// hang guard
	initial begin
		repeat (2000) @(posedge clock);
		fail_count++;
		stop_test();
	end
endmodule : test_fbs_sram
